// ==== dv/deas_fw_model.sv ====
// firmware-side bus master model driving the sequencer register port
`timescale 1ns/1ns
module deas_fw_model (
  input wire logic ref_clk_i,
  output logic [1:0] addr_o,
  output logic [7:0] wdata_o,
  output logic we_o,
  output logic re_o,
  input wire logic [7:0] rdata_i,
  input wire logic done_i
);
  initial begin
    addr_o = 2'h0;
    wdata_o = 8'h00;
    we_o = 1'b0;
    re_o = 1'b0;
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    wdata_o <= d;
    we_o <= 1'b1;
    @(posedge ref_clk_i);
    we_o <= 1'b0;
  endtask
  // enable then start on the very next cycle, one new bit per write
  task automatic arm(input logic [7:0] en, input logic [7:0] go);
    @(posedge ref_clk_i);
    addr_o <= 2'h3;
    wdata_o <= en;
    we_o <= 1'b1;
    @(posedge ref_clk_i);
    wdata_o <= go;
    @(posedge ref_clk_i);
    we_o <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    re_o <= 1'b1;
    @(posedge ref_clk_i);
    re_o <= 1'b0;
    #1 d = rdata_i;
  endtask
  // bounded: the timer must end inside the shortened counts
  task automatic wait_done(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 2000 && ok !== 1'b1; i++) begin
      @(posedge ref_clk_i);
      #1 ok = done_i;
    end
  endtask
endmodule

// ==== dv/deas_top_test.sv ====
// self-checking testbench of the data eeprom access sequencer
`timescale 1ns/1ns
module deas_top_test;
  import deas_pkg::*;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [1:0] addr;
  deas_byte_t wdata;
  logic we;
  logic re;
  deas_byte_t rdata_o;
  logic done_o;
  logic busy_o;
  logic ok;
  deas_byte_t v;
  int errors = 0;
  int check_count = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  // short timer counts keep the run brief; write counts even
  deas_top #(.ERASE0_CYC(19'd20), .WRITE0_CYC(19'd12), .ERASE1_CYC(19'd24),
    .WRITE1_CYC(19'd16)) u_deas_top (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata_o),
    .done_o(done_o), .busy_o(busy_o));
  deas_fw_model u_deas_fw_model (.ref_clk_i(ref_clk_i), .addr_o(addr), .wdata_o(wdata),
    .we_o(we), .re_o(re), .rdata_i(rdata_o), .done_i(done_o));
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rdchk(input string n, input logic [1:0] a, input logic [7:0] exp);
    u_deas_fw_model.rd(a, v);
    chk(n, v, exp);
  endtask
  task automatic fin(input logic [7:0] en, input logic [7:0] go);
    u_deas_fw_model.arm(en, go);
    u_deas_fw_model.wait_done(ok);
    chk("done", {7'h0, ok}, 8'h01);
    if (ok !== 1'b1) test_done();
  endtask
  // allow first, start in a later write; then poll the start bit under a bound
  task automatic fetch(input logic [7:0] c, input logic [7:0] exp);
    u_deas_fw_model.wr(2'h3, c & 8'hFE);
    u_deas_fw_model.wr(2'h3, c);
    for (int i = 0; i < 8; i++) begin
      u_deas_fw_model.rd(2'h3, v);
      if (v[0] === 1'b0) break;
    end
    chk("fetch_go", v, c & 8'hFE);
    rdchk("nv_data_port", 2'h2, exp);
  endtask
  task automatic prog(input logic [7:0] lo, input logic [7:0] d, input logic [7:0] cs);
    u_deas_fw_model.wr(2'h0, lo);
    u_deas_fw_model.wr(2'h2, d);
    fin(cs | 8'h08, cs | 8'h0C);
    rdchk("ctrl after write", 2'h3, cs);
  endtask
  task automatic t_reset();
    rdchk("addr_low", 2'h0, 8'h00);
    rdchk("addr_high", 2'h1, 8'h00);
    rdchk("data", 2'h2, 8'h00);
    rdchk("ctrl", 2'h3, 8'h00);
    u_deas_fw_model.wr(2'h1, 8'hFF);
    rdchk("addr_high", 2'h1, 8'h03);
    $display("test reset done");
  endtask
  task automatic t_byte();
    u_deas_fw_model.wr(2'h3, 8'h01);
    rdchk("ctrl", 2'h3, 8'h00);
    chk("busy", {7'h0, busy_o}, 8'h00);
    prog(8'h05, 8'hA5, 8'h00);
    // overwrite the port so only a real fetch can bring the byte back
    u_deas_fw_model.wr(2'h2, 8'h00);
    fetch(8'h03, 8'hA5);
    rdchk("data again", 2'h2, 8'hA5);
    u_deas_fw_model.wr(2'h3, 8'h04);
    rdchk("ctrl", 2'h3, 8'h00);
    u_deas_fw_model.wr(2'h3, 8'h08);
    u_deas_fw_model.wr(2'h0, 8'h0E);
    u_deas_fw_model.wr(2'h3, 8'h0C);
    rdchk("ctrl gap", 2'h3, 8'h08);
    chk("busy", {7'h0, busy_o}, 8'h00);
    u_deas_fw_model.wr(2'h3, 8'h00);
    prog(8'h0E, 8'h5A, 8'h00);
    prog(8'h0F, 8'h5A, 8'h80);
    $display("test byte done");
  endtask
  task automatic t_page();
    u_deas_fw_model.wr(2'h0, 8'h0E);
    u_deas_fw_model.wr(2'h3, 8'h10);
    u_deas_fw_model.wr(2'h2, 8'h77);
    fin(8'h50, 8'h70);
    rdchk("ctrl after erase", 2'h3, 8'h10);
    u_deas_fw_model.wr(2'h0, 8'h0E);
    u_deas_fw_model.wr(2'h3, 8'h12);
    fetch(8'h13, 8'h00);
    fetch(8'h13, 8'h5A);
    fetch(8'h13, 8'h5A);
    fin(8'h50, 8'h70);
    u_deas_fw_model.wr(2'h0, 8'h0F);
    fetch(8'h13, 8'h5A);
    $display("test page done");
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_byte();
    t_page();
    test_done();
  end
endmodule

// ==== hw/deas_map.svh ====
// register offsets, control bit positions, reset values and cycle timing of the sequencer
`ifndef DEAS_MAP_SVH
`define DEAS_MAP_SVH
`define DEAS_OFF_ADDR_LOW 2'h0
`define DEAS_OFF_ADDR_HIGH 2'h1
`define DEAS_OFF_DATA 2'h2
`define DEAS_OFF_CTRL 2'h3
`define DEAS_B_FETCH_GO 0
`define DEAS_B_FETCH_ALLOW 1
`define DEAS_B_PROG_GO 2
`define DEAS_B_PROG_ALLOW 3
`define DEAS_B_PAGE_SEL 4
`define DEAS_B_WIPE_GO 5
`define DEAS_B_WIPE_ALLOW 6
`define DEAS_B_CYC_SEL 7
`define DEAS_RST_BYTE 8'h00
`define DEAS_RST_ADDR 10'h000
`define DEAS_OFF_LAST 4'hF
`define DEAS_CLK_NS 10
`define DEAS_T_ERASE0_US 3200
`define DEAS_T_WRITE0_US 2200
`define DEAS_T_ERASE1_US 3700
`define DEAS_T_WRITE1_US 3000
`define DEAS_READ_CYC 19'h00002
`endif

// ==== hw/deas_pkg.sv ====
// types shared by the data eeprom access sequencer
package deas_pkg;
  typedef enum logic [2:0] {
    DEAS_IDLE,
    DEAS_READ,
    DEAS_ERASE,
    DEAS_WR_ERASE,
    DEAS_WR_PROG
  } deas_state_e;
  typedef logic [7:0] deas_byte_t;
  typedef logic [9:0] deas_addr_t;
  typedef logic [18:0] deas_cnt_t;
endpackage

// ==== hw/deas_top.sv ====
// data eeprom access sequencer: register port, 1024-byte array, timed read/erase/write
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "deas_map.svh"

// Overview of operation
// - byte mode: read byte at loaded address
// - read start ignored without fetch allow
// - read end clears go, byte in data
// - data port holds last byte read
// - page mode: reads up to sixteen bytes
// - each page read increments internal address
// - upper six bits page, lower four offset
// - offset saturates at 0FH, no carry
// - page erase limited to tagged bytes
// - tags cleared at reset, allow falling
// - page data writes tag and increment
// - erase timed, go cleared, completion event
// - erase end clears wipe allow
// - erased bytes read back zero
// - byte write needs allow then go next
// - no write when program allow low
// - write timed, go cleared at end
// - write end clears program allow
// - byte write erases target then programs
// - control bit layout, all zero reset
// - ten-bit address, unused high bits zero
module deas_top #(
  parameter deas_pkg::deas_cnt_t ERASE0_CYC = 19'(`DEAS_T_ERASE0_US * 1000 / `DEAS_CLK_NS),
  parameter deas_pkg::deas_cnt_t WRITE0_CYC = 19'(`DEAS_T_WRITE0_US * 1000 / `DEAS_CLK_NS),
  parameter deas_pkg::deas_cnt_t ERASE1_CYC = 19'(`DEAS_T_ERASE1_US * 1000 / `DEAS_CLK_NS),
  parameter deas_pkg::deas_cnt_t WRITE1_CYC = 19'(`DEAS_T_WRITE1_US * 1000 / `DEAS_CLK_NS)
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [1:0] addr_i,
  input wire deas_pkg::deas_byte_t wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output deas_pkg::deas_byte_t rdata_o,
  output logic done_o,
  output logic busy_o
);
  import deas_pkg::*;

  deas_byte_t mem_q [0:1023];
  deas_byte_t addr_low_q;
  logic [1:0] addr_high_q;
  deas_byte_t data_q;
  deas_byte_t ctrl_q;
  deas_addr_t cur_q;
  logic [15:0] tags_q;
  logic wipe_arm_q;
  logic prog_arm_q;
  logic wipe_allow_prev_q;
  deas_state_e state_q;
  deas_cnt_t cnt_q;
  deas_cnt_t erase_cyc;
  deas_cnt_t half_write_cyc;
  logic ctrl_wr;
  logic data_wr;
  logic idle;
  logic tick_end;
  logic rd_start;
  logic er_start;
  logic wr_start;
  logic wipe_fall;
  logic page_step;
  deas_byte_t rd_byte;
  logic [3:0] off_next;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  assign ctrl_wr = we_i && (addr_i == `DEAS_OFF_CTRL);
  assign data_wr = we_i && (addr_i == `DEAS_OFF_DATA);
  assign idle = (state_q == DEAS_IDLE);
  assign tick_end = !idle && (cnt_q == 19'h00000);
  assign rd_byte = mem_q[cur_q];
  assign wipe_fall = wipe_allow_prev_q && !ctrl_q[`DEAS_B_WIPE_ALLOW];
  // no rollover: the offset sticks at the page's last byte
  assign off_next = (cur_q[3:0] == `DEAS_OFF_LAST) ? `DEAS_OFF_LAST : cur_q[3:0] + 4'h1;

  // durations picked by the select bit; the timer is counted on the system clock
  assign erase_cyc = ctrl_q[`DEAS_B_CYC_SEL] ? ERASE1_CYC : ERASE0_CYC;
  // a byte write spends half its time erasing and half programming
  assign half_write_cyc = (ctrl_q[`DEAS_B_CYC_SEL] ? WRITE1_CYC : WRITE0_CYC) >> 1;

  assign rd_start = ctrl_wr && wdata_i[`DEAS_B_FETCH_GO] && ctrl_q[`DEAS_B_FETCH_ALLOW] &&
                    idle;
  assign er_start = ctrl_wr && wdata_i[`DEAS_B_WIPE_GO] && ctrl_q[`DEAS_B_WIPE_ALLOW] &&
                    wipe_arm_q && idle;
  assign wr_start = ctrl_wr && wdata_i[`DEAS_B_PROG_GO] && ctrl_q[`DEAS_B_PROG_ALLOW] &&
                    prog_arm_q && idle && !wdata_i[`DEAS_B_FETCH_GO];
  assign page_step = ctrl_q[`DEAS_B_PAGE_SEL] &&
                     ((state_q == DEAS_READ && tick_end) || (data_wr && idle));

  // arm flags live for exactly one cycle after allow goes from 0 to 1
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wipe_arm_q <= 1'b0;
      prog_arm_q <= 1'b0;
    end else begin
      wipe_arm_q <= ctrl_wr && wdata_i[`DEAS_B_WIPE_ALLOW] && !ctrl_q[`DEAS_B_WIPE_ALLOW];
      prog_arm_q <= ctrl_wr && wdata_i[`DEAS_B_PROG_ALLOW] && !ctrl_q[`DEAS_B_PROG_ALLOW];
    end
  end

  // address registers and the internal current address
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      addr_low_q <= `DEAS_RST_BYTE;
      addr_high_q <= 2'h0;
      cur_q <= `DEAS_RST_ADDR;
    end else if (we_i && addr_i == `DEAS_OFF_ADDR_LOW) begin
      addr_low_q <= wdata_i;
      cur_q <= {addr_high_q, wdata_i};
    end else if (we_i && addr_i == `DEAS_OFF_ADDR_HIGH) begin
      addr_high_q <= wdata_i[1:0];
      cur_q <= {wdata_i[1:0], addr_low_q};
    end else if (page_step) begin
      cur_q <= {cur_q[9:4], off_next};
    end
  end

  // control register: go bits only rise on a valid start and fall at cycle end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctrl_q <= `DEAS_RST_BYTE;
    end else begin
      if (ctrl_wr) begin
        ctrl_q[`DEAS_B_CYC_SEL] <= wdata_i[`DEAS_B_CYC_SEL];
        ctrl_q[`DEAS_B_WIPE_ALLOW] <= wdata_i[`DEAS_B_WIPE_ALLOW];
        ctrl_q[`DEAS_B_PAGE_SEL] <= wdata_i[`DEAS_B_PAGE_SEL];
        ctrl_q[`DEAS_B_PROG_ALLOW] <= wdata_i[`DEAS_B_PROG_ALLOW];
        ctrl_q[`DEAS_B_FETCH_ALLOW] <= wdata_i[`DEAS_B_FETCH_ALLOW];
      end
      if (rd_start) begin
        ctrl_q[`DEAS_B_FETCH_GO] <= 1'b1;
      end
      if (er_start) begin
        ctrl_q[`DEAS_B_WIPE_GO] <= 1'b1;
      end
      if (wr_start) begin
        ctrl_q[`DEAS_B_PROG_GO] <= 1'b1;
      end
      if (state_q == DEAS_READ && tick_end) begin
        ctrl_q[`DEAS_B_FETCH_GO] <= 1'b0;
      end
      if (state_q == DEAS_ERASE && tick_end) begin
        ctrl_q[`DEAS_B_WIPE_GO] <= 1'b0;
        ctrl_q[`DEAS_B_WIPE_ALLOW] <= 1'b0;
      end
      if (state_q == DEAS_WR_PROG && tick_end) begin
        ctrl_q[`DEAS_B_PROG_GO] <= 1'b0;
        ctrl_q[`DEAS_B_PROG_ALLOW] <= 1'b0;
      end
    end
  end

  // tags: set wins over the clear caused by allow falling in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wipe_allow_prev_q <= 1'b0;
      tags_q <= 16'h0000;
    end else begin
      wipe_allow_prev_q <= ctrl_q[`DEAS_B_WIPE_ALLOW];
      if (data_wr && idle && ctrl_q[`DEAS_B_PAGE_SEL]) begin
        tags_q <= (wipe_fall ? 16'h0000 : tags_q) | (16'h0001 << cur_q[3:0]);
      end else if (wipe_fall) begin
        tags_q <= 16'h0000;
      end
    end
  end

  // data port: firmware writes, or the fetched byte at read end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      data_q <= `DEAS_RST_BYTE;
    end else if (state_q == DEAS_READ && tick_end) begin
      data_q <= rd_byte;
    end else if (data_wr) begin
      data_q <= wdata_i;
    end
  end

  // sequencer and its cycle timer
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= DEAS_IDLE;
      cnt_q <= 19'h00000;
    end else begin
      case (state_q)
        DEAS_IDLE: begin
          if (rd_start) begin
            state_q <= DEAS_READ;
            cnt_q <= `DEAS_READ_CYC - 19'h00001;
          end else if (er_start) begin
            state_q <= DEAS_ERASE;
            cnt_q <= erase_cyc - 19'h00001;
          end else if (wr_start) begin
            state_q <= DEAS_WR_ERASE;
            cnt_q <= half_write_cyc - 19'h00001;
          end
        end
        DEAS_WR_ERASE: begin
          if (tick_end) begin
            state_q <= DEAS_WR_PROG;
            cnt_q <= half_write_cyc - 19'h00001;
          end else begin
            cnt_q <= cnt_q - 19'h00001;
          end
        end
        DEAS_READ, DEAS_ERASE, DEAS_WR_PROG: begin
          if (tick_end) begin
            state_q <= DEAS_IDLE;
          end else begin
            cnt_q <= cnt_q - 19'h00001;
          end
        end
        default: begin
          state_q <= DEAS_IDLE;
          cnt_q <= 19'h00000;
        end
      endcase
    end
  end

  // array updates; no reset so the array maps onto plain storage
  always_ff @(posedge ref_clk_i) begin
    if (state_q == DEAS_ERASE && tick_end) begin
      if (ctrl_q[`DEAS_B_PAGE_SEL]) begin
        for (int i = 0; i < 16; i++) begin
          if (tags_q[i]) begin
            mem_q[{cur_q[9:4], 4'(i)}] <= `DEAS_RST_BYTE;
          end
        end
      end else begin
        mem_q[cur_q] <= `DEAS_RST_BYTE;
      end
    end else if (state_q == DEAS_WR_ERASE && tick_end) begin
      mem_q[cur_q] <= `DEAS_RST_BYTE;
    end else if (state_q == DEAS_WR_PROG && tick_end) begin
      mem_q[cur_q] <= data_q;
    end
  end

  // register read port and status outputs
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_o <= `DEAS_RST_BYTE;
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      done_o <= tick_end && (state_q == DEAS_ERASE || state_q == DEAS_WR_PROG);
      busy_o <= !idle || rd_start || er_start || wr_start;
      if (re_i) begin
        case (addr_i)
          `DEAS_OFF_ADDR_LOW: rdata_o <= addr_low_q;
          `DEAS_OFF_ADDR_HIGH: rdata_o <= {6'h00, addr_high_q};
          `DEAS_OFF_DATA: rdata_o <= data_q;
          default: rdata_o <= ctrl_q;
        endcase
      end else begin
        rdata_o <= `DEAS_RST_BYTE;
      end
    end
  end

  a_fetch_start: assert property (rd_start |=> ctrl_q[`DEAS_B_FETCH_GO] && state_q == DEAS_READ)
    else $error("valid read request did not start a read");
  a_fetch_ignored: assert property (ctrl_wr && wdata_i[`DEAS_B_FETCH_GO] &&
      !ctrl_q[`DEAS_B_FETCH_ALLOW] && idle |=> !ctrl_q[`DEAS_B_FETCH_GO])
    else $error("read started without fetch allow");
  a_read_result: assert property (state_q == DEAS_READ && tick_end |=>
      !ctrl_q[`DEAS_B_FETCH_GO] && data_q == $past(rd_byte))
    else $error("read end did not clear go or load data");
  a_data_hold: assert property (idle && !data_wr |=> $stable(data_q))
    else $error("data port changed without an operation");
  a_page_step: assert property (page_step && !we_i && cur_q[3:0] != `DEAS_OFF_LAST |=>
      cur_q[3:0] == $past(cur_q[3:0]) + 4'h1 && cur_q[9:4] == $past(cur_q[9:4]))
    else $error("page offset did not step within the page");
  a_off_hold: assert property (page_step && !we_i && cur_q[3:0] == `DEAS_OFF_LAST |=>
      cur_q == $past(cur_q))
    else $error("page offset rolled over");
  a_tag_clear: assert property (wipe_fall && !data_wr |=> tags_q == 16'h0000)
    else $error("tags survived wipe allow falling");
  a_erase_end: assert property (state_q == DEAS_ERASE && tick_end |=>
      done_o && !ctrl_q[`DEAS_B_WIPE_GO] && !ctrl_q[`DEAS_B_WIPE_ALLOW] ##1 !done_o)
    else $error("erase end did not clear bits or pulse done");
  a_prog_refused: assert property (ctrl_wr && wdata_i[`DEAS_B_PROG_GO] &&
      !ctrl_q[`DEAS_B_PROG_ALLOW] |=> state_q != DEAS_WR_ERASE)
    else $error("write started without program allow");
  a_write_order: assert property (wr_start |=> state_q == DEAS_WR_ERASE ##1
      state_q inside {DEAS_WR_ERASE, DEAS_WR_PROG})
    else $error("byte write did not erase first");
  a_write_end: assert property (state_q == DEAS_WR_PROG && tick_end |=>
      done_o && !ctrl_q[`DEAS_B_PROG_GO] && !ctrl_q[`DEAS_B_PROG_ALLOW] && idle)
    else $error("write end did not clear bits or pulse done");

  // launches: only a back-to-back allow/go pair starts an erase or a byte write
  a_erase_start: assert property (er_start |=>
      state_q == DEAS_ERASE && ctrl_q[`DEAS_B_WIPE_GO])
    else $error("valid erase request did not start an erase");

  a_erase_gap: assert property (ctrl_wr && wdata_i[`DEAS_B_WIPE_GO] &&
      !wipe_arm_q && idle |=> !ctrl_q[`DEAS_B_WIPE_GO])
    else $error("erase started without a fresh wipe allow");

  a_write_start: assert property (wr_start |=>
      ctrl_q[`DEAS_B_PROG_GO] && busy_o)
    else $error("valid write request did not start a write");

  a_write_gap: assert property (ctrl_wr && wdata_i[`DEAS_B_PROG_GO] &&
      !prog_arm_q && idle |=> !ctrl_q[`DEAS_B_PROG_GO])
    else $error("write started without a fresh program allow");

  // a running cycle owns the timer; a second start would corrupt it
  a_busy_refuse: assert property (!idle && ctrl_wr && wdata_i[`DEAS_B_FETCH_GO] &&
      !ctrl_q[`DEAS_B_FETCH_GO] |=> !ctrl_q[`DEAS_B_FETCH_GO])
    else $error("read started while another cycle ran");

  a_busy_flag: assert property (!idle |=> busy_o)
    else $error("busy low while a cycle ran");

  // completion event toward the interrupt controller
  a_done_single: assert property (done_o |=> !done_o)
    else $error("completion event longer than one cycle");

  a_done_cause: assert property (done_o |-> $past(tick_end) &&
      ($past(state_q) == DEAS_ERASE || $past(state_q) == DEAS_WR_PROG))
    else $error("completion event without an erase or write end");

  // register port views
  a_addr_high_read: assert property (re_i && addr_i == `DEAS_OFF_ADDR_HIGH |=>
      rdata_o[7:2] == 6'h00)
    else $error("unused address bits read nonzero");

  a_ctrl_read: assert property (re_i && addr_i == `DEAS_OFF_CTRL |=>
      rdata_o == $past(ctrl_q))
    else $error("control read did not return the control bits");

  a_cur_reload: assert property (we_i && addr_i == `DEAS_OFF_ADDR_LOW |=>
      cur_q == {$past(addr_high_q), $past(wdata_i)})
    else $error("address low write did not reload current address");

  // read length and array effects
  a_read_length: assert property (rd_start |=> state_q == DEAS_READ ##1
      tick_end ##1 !ctrl_q[`DEAS_B_FETCH_GO])
    else $error("read cycle length wrong");

  a_byte_erase: assert property (state_q == DEAS_WR_ERASE && tick_end |=>
      mem_q[$past(cur_q)] == `DEAS_RST_BYTE)
    else $error("byte write did not erase the target first");

  a_byte_program: assert property (state_q == DEAS_WR_PROG && tick_end |=>
      mem_q[$past(cur_q)] == $past(data_q))
    else $error("byte write did not program the data");

  a_page_tag: assert property (data_wr && idle && ctrl_q[`DEAS_B_PAGE_SEL] |=>
      tags_q[$past(cur_q[3:0])])
    else $error("page data write did not tag its offset");
endmodule
